//--- src/accd_pkg.sv
// Purpose: Constants and types for the acquisition chain control and downsample rate registers.
// Assumes: 16-bit core data path, byte addresses within the chain register page.
// Notes:
// Operation
// - Upper control byte masks writes to the matching lower bit; zero keeps it.
// - Bit 7 set shorts current and voltage converter inputs for offset measurement.
// - Bit 6 enables temperature supply frequency compensation, allowing a pin capacitor.
// - Bit 5 selects temperature converter standard gain, default one, test only.
// - Bit 4 selects voltage converter standard gain, default one, test only.
// - Bit 3 selects current converter standard gain, default one, test only.
// - Bit 2 adds about 100 ns input delay on temperature channel.
// - Bit 1 adds about 100 ns input delay on voltage channel.
// - Bit 0 adds about 100 ns input delay on current channel.
// - Rate field sets combined ratio; first sinc3 stage fixed at eight.
// - Codes 001, 010, 011 give ratios 64, 128, 256.
// - Code 101 gives ratio 1024, a 500 Hz output rate.
// - Codes 000, 100, 110, 111 give ratio 512; 100 is reset.
// - Offsets decode from base 0x0200 blocking and 0x0300 non-blocking.
package accd_pkg;
  localparam logic [15:0] ACCD_BASE_BLOCK   = 16'h0200;
  localparam logic [15:0] ACCD_BASE_NONBLK  = 16'h0300;
  localparam logic [7:0]  ACCD_OFS_CTRL0    = 8'h5E;
  localparam logic [7:0]  ACCD_OFS_RATE     = 8'h60;
  localparam logic [7:0]  ACCD_CTRL0_RESET  = 8'h38;
  localparam logic [2:0]  ACCD_RATE_RESET   = 3'h4;
  localparam int          ACCD_STAGE1_RATIO = 8;
  localparam int          ACCD_CLK_NS       = 100;
  localparam int          ACCD_IN_DELAY_NS  = 100;
  localparam int          ACCD_IN_DELAY_CYC =
    (ACCD_IN_DELAY_NS + ACCD_CLK_NS - 1) / ACCD_CLK_NS;
  localparam int          ACCD_POS_SHORT    = 7;
  localparam int          ACCD_POS_EXT_CAPACITOR_SEL     = 6;
  localparam int          ACCD_POS_TGAIN    = 5;
  localparam int          ACCD_POS_VGAIN    = 4;
  localparam int          ACCD_POS_CGAIN    = 3;
  localparam int          ACCD_POS_TDLY     = 2;
  localparam int          ACCD_POS_VDLY     = 1;
  localparam int          ACCD_POS_CDLY     = 0;

  typedef struct packed {
    logic        input_short;
    logic        ext_capacitor_sel;
    logic        temp_conv_gain_std;
    logic        volt_conv_gain_std;
    logic        curr_conv_gain_std;
    logic        temp_input_delay_on;
    logic        volt_input_delay_on;
    logic        curr_input_delay_on;
  } accd_ctrl_t;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [1:0]  be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } accd_bus_t;

  typedef struct packed {
    logic [10:0] total_ratio;
    logic [7:0]  stage2_ratio;
  } accd_ratio_t;
endpackage : accd_pkg

//--- src/accd_delay.sv
// Purpose: Optional fixed delay of one sigma-delta input bit stream.
// Assumes: Stream sampled on the core clock.
// Notes: Selection taken combinationally, so a change applies at once.
`timescale 1ns/100ps
`default_nettype none
module accd_delay
  import accd_pkg::*;
#(
  parameter int DEPTH = ACCD_IN_DELAY_CYC
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_en,
  input  wire logic i_bit,
  output logic      o_bit
);
  logic [DEPTH-1:0] pipe;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pipe <= '0;
    end else begin
      // Oldest bit drops off the top; the cast keeps the shift legal for DEPTH of one
      pipe <= DEPTH'({pipe, i_bit});
    end
  end

  assign o_bit = i_en ? pipe[DEPTH-1] : i_bit;
endmodule // accd_delay
`default_nettype wire

//--- src/accd_regs.sv
// Purpose: Chain control and downsample rate registers with their decoded controls.
// Assumes: Core bus with select, write and two byte enables, 16-bit data.
// Notes: A control write missing either byte is ignored; the mask must travel with the value.
`timescale 1ns/100ps
`default_nettype none
module accd_regs
  import accd_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire accd_pkg::accd_bus_t i_bus,
  output logic [15:0]            o_rdata,
  output logic                   o_hit,
  output accd_pkg::accd_ctrl_t   o_ctrl,
  output logic [2:0]             o_downsample_ratio_sel,
  output accd_pkg::accd_ratio_t  o_ratio,
  input  wire logic [2:0]        i_sd_bits,
  output logic [2:0]             o_sd_bits
);
  import accd_pkg::*;

  logic [7:0]  chain_control_zero;
  logic [2:0]  downsample_ratio_sel;
  logic [7:0]  next_ctrl;
  logic [15:0] next_rdata;
  logic [7:0]  page_ofs;
  logic        in_page;
  logic        hit_ctrl;
  logic        hit_rate;
  logic        wr_ctrl;
  logic        wr_rate;

  function automatic logic [7:0] accd_stage2(input logic [2:0] code);
    unique case (code)
      3'h1:    accd_stage2 = 8'h08;
      3'h2:    accd_stage2 = 8'h10;
      3'h3:    accd_stage2 = 8'h20;
      3'h5:    accd_stage2 = 8'h80;
      default: accd_stage2 = 8'h40;
    endcase
  endfunction

  assign in_page  = (i_bus.addr[15:8] == ACCD_BASE_BLOCK[15:8]) ||
                    (i_bus.addr[15:8] == ACCD_BASE_NONBLK[15:8]);
  assign page_ofs = i_bus.addr[7:0];
  assign hit_ctrl = in_page && (page_ofs == ACCD_OFS_CTRL0);
  assign hit_rate = in_page && (page_ofs == ACCD_OFS_RATE);
  assign wr_ctrl  = i_bus.sel && i_bus.wr && hit_ctrl && (&i_bus.be);
  assign wr_rate  = i_bus.sel && i_bus.wr && hit_rate && i_bus.be[0];
  assign next_ctrl = (chain_control_zero & ~i_bus.wdata[15:8]) |
                     (i_bus.wdata[7:0] & i_bus.wdata[15:8]);
  assign next_rdata = hit_ctrl ? {8'h00, chain_control_zero} :
                      hit_rate ? {13'h0000, downsample_ratio_sel} : 16'h0000;
  assign o_hit = i_bus.sel && (hit_ctrl || hit_rate);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      chain_control_zero <= ACCD_CTRL0_RESET;
    end else if (wr_ctrl) begin
      chain_control_zero <= next_ctrl;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      downsample_ratio_sel <= ACCD_RATE_RESET;
    end else if (wr_rate) begin
      downsample_ratio_sel <= i_bus.wdata[2:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_bus.sel && !i_bus.wr) begin
      o_rdata <= next_rdata;
    end
  end

  assign o_ctrl = accd_ctrl_t'(chain_control_zero);
  assign o_downsample_ratio_sel = downsample_ratio_sel;
  assign o_ratio.stage2_ratio = accd_stage2(downsample_ratio_sel);
  assign o_ratio.total_ratio  = {accd_stage2(downsample_ratio_sel), 3'h0};

  accd_delay u_tdly (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_en       (chain_control_zero[ACCD_POS_TDLY]),
    .i_bit      (i_sd_bits[2]),
    .o_bit      (o_sd_bits[2])
  );
  accd_delay u_vdly (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_en       (chain_control_zero[ACCD_POS_VDLY]),
    .i_bit      (i_sd_bits[1]),
    .o_bit      (o_sd_bits[1])
  );
  accd_delay u_cdly (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_en       (chain_control_zero[ACCD_POS_CDLY]),
    .i_bit      (i_sd_bits[0]),
    .o_bit      (o_sd_bits[0])
  );
endmodule // accd_regs
`default_nettype wire

//--- verification/accd_regs_props.sv
// Purpose: Port checks for the chain control and rate registers.
// Assumes: One clock, sync active-low reset.
// Notes: Only the 0x5E and 0x60 offsets are modelled.
`timescale 1ns/100ps
`default_nettype none
module accd_regs_props
  import accd_pkg::*;
(
  input wire logic                  i_core_clk,
  input wire logic                  i_rst_n,
  input wire accd_pkg::accd_bus_t   i_bus,
  input wire logic [15:0]           o_rdata,
  input wire logic                  o_hit,
  input wire accd_pkg::accd_ctrl_t  o_ctrl,
  input wire logic [2:0]            o_downsample_ratio_sel,
  input wire accd_pkg::accd_ratio_t o_ratio,
  input wire logic [2:0]            i_sd_bits,
  input wire logic [2:0]            o_sd_bits
);
  wire logic pg = i_bus.addr[15:9] == 7'h01;
  wire logic rd = i_bus.sel && !i_bus.wr;
  wire logic wq = i_bus.sel && i_bus.wr && pg;
  wire logic wc = wq && i_bus.be == 2'h3 && i_bus.addr[7:0] == ACCD_OFS_CTRL0;
  wire logic [2:0] s = o_downsample_ratio_sel;
  // Unlisted codes fall back to 512
  wire logic [10:0] xr = s == 3'h1 ? 11'h040 : s == 3'h2 ? 11'h080 :
                         s == 3'h3 ? 11'h100 : s == 3'h5 ? 11'h400 : 11'h200;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_ctrl_wr; wc; endsequence
  sequence s_dly_on; o_ctrl[2:0] == 3'h7 ##1 o_ctrl[2:0] == 3'h7; endsequence
  a_mask_gates: assert property (s_ctrl_wr |=> o_ctrl ==
    (($past(i_bus.wdata[7:0]) & $past(i_bus.wdata[15:8])) |
     ($past(o_ctrl) & ~$past(i_bus.wdata[15:8]))))
    else $error("masked write");
  a_ctrl_holds: assert property (!wc |=> $stable(o_ctrl)) else $error("ctrl moved");
  a_rate_write: assert property (wq && i_bus.be[0] && i_bus.addr[7:0] == ACCD_OFS_RATE
    |=> s == $past(i_bus.wdata[2:0])) else $error("rate write");
  a_ratio_map: assert property (
    o_ratio.total_ratio == xr) else $error("ratio");
  a_ctrl_read: assert property (rd && pg && i_bus.addr[7:0] == ACCD_OFS_CTRL0
    |=> o_rdata == {8'h00, $past(o_ctrl)}) else $error("ctrl read");
  a_off_page: assert property (rd && !pg |=> o_rdata == 16'h0000) else $error("off page");
  a_direct_path: assert property (
    o_ctrl[2:0] == 3'h0 |-> o_sd_bits == i_sd_bits) else $error("direct path");
  a_delay_path: assert property (
    s_dly_on |-> o_sd_bits == $past(i_sd_bits)) else $error("delay path");
  a_reset_vals: assert property (
    $rose(i_rst_n) |-> o_ctrl == ACCD_CTRL0_RESET && s == ACCD_RATE_RESET)
    else $error("reset values");
  a_hit_decode: assert property (
    o_hit == (i_bus.sel && pg && (i_bus.addr[7:0] == ACCD_OFS_CTRL0 ||
                                  i_bus.addr[7:0] == ACCD_OFS_RATE)))
    else $error("hit decode");
endmodule // accd_regs_props
bind accd_regs accd_regs_props accd_regs_props_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_bus(i_bus), .o_rdata(o_rdata), .o_hit(o_hit), .o_ctrl(o_ctrl), .o_ratio(o_ratio),
  .o_downsample_ratio_sel(o_downsample_ratio_sel), .i_sd_bits(i_sd_bits), .o_sd_bits(o_sd_bits));
`default_nettype wire

//--- verification/acq_chain_ctrl_and_decimation_tb.sv
// Purpose: Register-level test of chain control and rate.
// Assumes: Read data settles one edge after the request.
// Notes: Streams are checked once per new input value around a delay change; the two cycles of the write go unchecked.
`timescale 1ns/100ps
`default_nettype none
module acq_chain_ctrl_and_decimation_tb;
  import accd_pkg::*;
  logic        clk = 0;
  logic        rst_n = 0;
  accd_bus_t   bus = '0;
  logic [2:0]  sd = '0;
  logic [15:0] rdata;
  accd_ctrl_t  ctrl;
  logic [2:0]  sdo;
  accd_ratio_t ratio;
  int          bad_count = 0;
  int          compares = 0;
  logic [10:0] xr [8] = '{11'h200, 11'h040, 11'h080, 11'h100, 11'h200, 11'h400, 11'h200, 11'h200};
  accd_regs accd_regs_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
    .o_hit(), .o_ctrl(ctrl), .o_downsample_ratio_sel(), .o_ratio(ratio), .i_sd_bits(sd),
    .o_sd_bits(sdo));
  initial forever #50 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] be, input logic [15:0] a, d);
    @(posedge clk) bus <= '{1'b1, w, be, a, d};
    @(posedge clk) bus.sel <= 1'b0;
    #1;
  endtask
  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("ctrl", 16'(ctrl), 16'h0038);
    acc(1'b1, 2'h3, 16'h025E, 16'h8080);
    chk("short", 16'(ctrl), 16'h00B8);
    acc(1'b1, 2'h3, 16'h025E, 16'h00FF);
    chk("mask", 16'(ctrl), 16'h00B8);
    acc(1'b1, 2'h1, 16'h025E, 16'hFF00);
    chk("half", 16'(ctrl), 16'h00B8);
    acc(1'b1, 2'h3, 16'h025E, 16'hFF40);
    chk("ext_capacitor_sel", 16'(ctrl), 16'h0040);
    acc(1'b1, 2'h3, 16'h035E, 16'h0707);
    acc(1'b0, 2'h3, 16'h025E, 16'h0000);
    chk("ctrl_rd", rdata, 16'h0047);
    for (int k = 1; k < 8; k++) begin
      @(posedge clk) sd <= 3'(k);
      #1;
      chk("sd", 16'(sdo), 16'((k < 6) ? k - 1 : k));
      if (k == 5) acc(1'b1, 2'h3, 16'h025E, 16'h0700);
    end
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 2'h1, 16'h0260, 16'(c));
      chk("ratio", 16'(ratio.total_ratio), 16'(xr[c]));
      chk("stage2", 16'(ratio.stage2_ratio), 16'(xr[c] / 8));
      acc(1'b0, 2'h3, 16'h0360, 16'h0000);
      chk("rate_rd", rdata, 16'(c));
    end
    // Mid-run reset: control 0x40, rate 7 and read data 7 must all fall back
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("ctrl_rst", 16'(ctrl), 16'h0038);
    chk("rdata_rst", rdata, 16'h0000);
    acc(1'b0, 2'h3, 16'h0260, 16'h0000);
    chk("rate_rst", rdata, 16'h0004);
    acc(1'b0, 2'h3, 16'h0462, 16'h0000);
    chk("off_page", rdata, 16'h0000);
    test_done;
  end
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    test_done;
  end
endmodule // acq_chain_ctrl_and_decimation_tb
`default_nettype wire
